//--- ats_cfg.svh
// Behaviour
// RL1: sequencer has exactly four states: idle, initiated, wait-arm, wait-trigger.
// RL2: power-up, reset or abort always returns the sequencer to idle.
// RL3: configuration such as counts and arm settings loads only while idle.
// RL4: one sequencer drives both channels, so both share one state.
// RL5: a channel-qualified setting write replaces the shared setting for both channels.
// RL6: nonzero pre-arm count: request_a goes straight to wait-trigger and samples.
// RL7: pre-arm sampling runs until pre-arm count reached and an arm received.
// RL8: after the arm is accepted each sample needs a trigger event.
// RL9: pre-arm burst ends when pre plus post samples equal trigger count.
// RL10: zero pre-arm count: request_a goes to wait-arm without sampling.
// RL11: an arm event while waiting for arm moves to wait-trigger.
// RL12: post-arm path stays waiting for triggers until trigger count samples taken.
// RL13: after a burst, if arm count unmet, stay initiated and repeat.
// RL14: no sample is taken outside the wait-trigger state.
// RL15: when completed bursts reach the arm count, return to idle.
// RL16: two arm sources may be active; first event on either arms.
// RL17: force arm arms regardless of source, decrements remaining arms, no delay.
// RL18: arm count 1..65535 or unlimited post-arm only; 1..128 with pre-arm.
// RL19: nonzero pre-arm count selects pre-arm path, otherwise post-arm-only path.
`ifndef ATS_CFG_SVH
`define ATS_CFG_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define ATS_ADDR_W        8
`define ATS_OFF_CMD       8'h00
`define ATS_OFF_PRE_CH1   8'h04
`define ATS_OFF_PRE_CH2   8'h08
`define ATS_OFF_TRIG      8'h0C
`define ATS_OFF_ARMCNT    8'h10
`define ATS_OFF_SRC       8'h14
`define ATS_OFF_STAT      8'h18
`define ATS_OFF_PROG      8'h1C
`define ATS_OFF_SAMP      8'h20

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define ATS_CMD_INIT      0
`define ATS_CMD_ABORT     1
`define ATS_CMD_FORCE     2
`define ATS_SRC1_LSB      0
`define ATS_SRC2_LSB      8
`define ATS_SRC_W         4
`define ATS_PROG_LEFT_LSB 16

// ----------------------------------------------------------------------------
// codes, limits and reset values
// ----------------------------------------------------------------------------
`define ATS_SRC_HOLD      4'h0
`define ATS_SRC_IMM       4'hF
`define ATS_PRE_ARM_MAX   16'h0080
`define ATS_RST_PRE       20'h00000
`define ATS_RST_TRIG      20'h00001
`define ATS_RST_ARMCNT    16'h0001
`define ATS_RST_SRC1      `ATS_SRC_IMM
`define ATS_RST_SRC2      `ATS_SRC_HOLD
`define ATS_RESP_OKAY     2'h0
`define ATS_RESP_SLVERR   2'h2

`endif

//--- ats_pkg.sv
package ats_pkg;

   // ----------------------------------------------------------------------------
   // sequencer states, gray along idle, initiated, wait-arm, wait-trigger
   // ----------------------------------------------------------------------------
   typedef enum logic [1:0] {
      ATS_IDLE  = 2'h0,
      ATS_INIT  = 2'h1,
      ATS_WARM  = 2'h3,
      ATS_WTRIG = 2'h2
   } ats_state_t;

endpackage : ats_pkg

//--- ats_arm_sel.sv
`timescale 1ns/1ps
`default_nettype none
`include "ats_cfg.svh"
module ats_arm_sel #(
   parameter int ARM_N = 8
) (
   // source selects
   input  wire logic [`ATS_SRC_W-1:0] src1,
   input  wire logic [`ATS_SRC_W-1:0] src2,
   // arm lines
   input  wire logic [ARM_N-1:0]      arm_in,
   // qualified arm
   output logic                       arm_event
);

   // ----------------------------------------------------------------------------
   // per-source qualification
   // ----------------------------------------------------------------------------
   wire  [ARM_N:0]            ext = {arm_in, 1'b0};
   wire  [`ATS_SRC_W-1:0]     src [2];
   logic [1:0]                hit;

   assign src[0] = src1;
   assign src[1] = src2;

   for (genvar i = 0; i < 2; i++) begin : g_src
      wire in_range = (32'(src[i]) <= ARM_N);
      wire imm      = (i == 0) && (src[i] == `ATS_SRC_IMM);
      assign hit[i] = imm || (in_range && (src[i] != `ATS_SRC_HOLD) && ext[src[i]]);
   end

   assign arm_event = |hit; // see RL16

endmodule : ats_arm_sel
`default_nettype wire

//--- ats_axil.sv
`timescale 1ns/1ps
`default_nettype none
`include "ats_cfg.svh"
module ats_axil (
   // clock and reset
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   // write channels
   input  wire logic [`ATS_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   // read channels
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   // register side
   output logic                        wr_stb,
   output logic [`ATS_ADDR_W-1:0]      wr_addr,
   output logic [31:0]                 wr_data,
   output logic [3:0]                  wr_strb,
   input  wire logic                   wr_hit,
   input  wire logic [31:0]            rd_data,
   input  wire logic                   rd_hit
);

   // ----------------------------------------------------------------------------
   // handshake decode
   // ----------------------------------------------------------------------------
   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take  = s_axi_wvalid && s_axi_wready;
   wire b_done  = s_axi_bvalid && s_axi_bready;
   wire ar_take = s_axi_arvalid && s_axi_arready;
   wire r_done  = s_axi_rvalid && s_axi_rready;

   assign wr_stb = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

   // ----------------------------------------------------------------------------
   // write path
   // ----------------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `ATS_RESP_OKAY;
         wr_addr       <= '0;
         wr_data       <= '0;
         wr_strb       <= '0;
      end else begin
         if (aw_take) begin
            s_axi_awready <= 1'b0;
            wr_addr       <= s_axi_awaddr;
         end
         if (w_take) begin
            s_axi_wready <= 1'b0;
            wr_data      <= s_axi_wdata;
            wr_strb      <= s_axi_wstrb;
         end
         if (wr_stb) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `ATS_RESP_OKAY : `ATS_RESP_SLVERR;
         end
         if (b_done) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= `ATS_RESP_OKAY;
      end else if (ar_take) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_hit ? rd_data : 32'h0000_0000;
         s_axi_rresp   <= rd_hit ? `ATS_RESP_OKAY : `ATS_RESP_SLVERR;
      end else if (r_done) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

endmodule : ats_axil
`default_nettype wire

//--- ats_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ats_cfg.svh"
module ats_top #(
   parameter int CNT_W = 20,
   parameter int ARM_W = 16,
   parameter int ARM_N = 8
) (
   // clock and reset
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   // axi4-lite write
   input  wire logic [`ATS_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   // axi4-lite read
   input  wire logic [`ATS_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   // arm and trigger events
   input  wire logic [ARM_N-1:0]       arm_in,
   input  wire logic                   trigger_in,
   // sample path, both channels
   output logic [1:0]                  sample_take,
   output logic                        seq_armed,
   output logic [1:0]                  seq_state,
   output logic                        burst_done
);

   // ----------------------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------------------
   ats_pkg::ats_state_t         state;
   ats_pkg::ats_state_t         next_state;
   logic [CNT_W-1:0]            pre_cfg;
   logic [CNT_W-1:0]            trig_cfg;
   logic [ARM_W-1:0]            arm_cfg;
   logic [`ATS_SRC_W-1:0]       src1_cfg;
   logic [`ATS_SRC_W-1:0]       src2_cfg;
   logic [CNT_W-1:0]            pre_cnt;
   logic [CNT_W-1:0]            post_cnt;
   logic [ARM_W-1:0]            burst_cnt;
   logic [ARM_W-1:0]            arm_left;
   logic                        armed;
   logic                        arm_seen;
   logic                        cfg_err;
   logic                        wr_stb;
   logic [`ATS_ADDR_W-1:0]      wr_addr;
   logic [31:0]                 wr_data;
   logic [3:0]                  wr_strb;
   logic [31:0]                 rd_data;
   logic                        sel_arm;
   logic [31:0]                 merged;
   logic                        wr_hit;
   logic                        rd_hit;

   // ----------------------------------------------------------------------------
   // bus slave
   // ----------------------------------------------------------------------------
   ats_axil u_axil (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .wr_stb        (wr_stb),
      .wr_addr       (wr_addr),
      .wr_data       (wr_data),
      .wr_strb       (wr_strb),
      .wr_hit        (wr_hit),
      .rd_data       (rd_data),
      .rd_hit        (rd_hit)
   );

   // ----------------------------------------------------------------------------
   // arm source selection
   // ----------------------------------------------------------------------------
   ats_arm_sel #(
      .ARM_N (ARM_N)
   ) u_arm_sel (
      .src1      (src1_cfg),
      .src2      (src2_cfg),
      .arm_in    (arm_in),
      .arm_event (sel_arm)
   );

   // ----------------------------------------------------------------------------
   // write decode
   // ----------------------------------------------------------------------------
   wire is_idle   = (state == ats_pkg::ATS_IDLE);
   wire a_cmd     = (wr_addr == `ATS_OFF_CMD);
   wire a_pre     = (wr_addr == `ATS_OFF_PRE_CH1) || (wr_addr == `ATS_OFF_PRE_CH2);
   wire a_trig    = (wr_addr == `ATS_OFF_TRIG);
   wire a_armcnt  = (wr_addr == `ATS_OFF_ARMCNT);
   wire a_src     = (wr_addr == `ATS_OFF_SRC);
   wire a_cfg     = a_pre || a_trig || a_armcnt || a_src;
   assign wr_hit  = a_cmd || a_cfg;
   wire cfg_wr    = wr_stb && a_cfg;
   wire cfg_ok    = cfg_wr && is_idle;                          // see RL3
   wire cfg_refuse = cfg_wr && !is_idle;                        // see RL3
   wire cmd_wr    = wr_stb && a_cmd && wr_strb[0];
   wire init_req  = cmd_wr && wr_data[`ATS_CMD_INIT];
   wire abort_req = cmd_wr && wr_data[`ATS_CMD_ABORT];
   wire force_req = cmd_wr && wr_data[`ATS_CMD_FORCE];

   always_comb begin
      for (int b = 0; b < 4; b++) begin
         merged[8*b +: 8] = wr_strb[b] ? wr_data[8*b +: 8] : 8'h00;
      end
   end

   // ----------------------------------------------------------------------------
   // read decode
   // ----------------------------------------------------------------------------
   wire r_stat = (s_axi_araddr == `ATS_OFF_STAT);
   wire r_prog = (s_axi_araddr == `ATS_OFF_PROG);
   wire r_samp = (s_axi_araddr == `ATS_OFF_SAMP);
   wire r_pre  = (s_axi_araddr == `ATS_OFF_PRE_CH1) || (s_axi_araddr == `ATS_OFF_PRE_CH2);
   wire r_trig = (s_axi_araddr == `ATS_OFF_TRIG);
   wire r_arm  = (s_axi_araddr == `ATS_OFF_ARMCNT);
   wire r_src  = (s_axi_araddr == `ATS_OFF_SRC);
   wire r_cmd  = (s_axi_araddr == `ATS_OFF_CMD);
   assign rd_hit = r_stat || r_prog || r_samp || r_pre || r_trig || r_arm || r_src || r_cmd;
   wire [31:0] stat_word = {27'h0000000, cfg_err, arm_seen, armed, 2'(state)};
   wire [31:0] prog_word = {arm_left, burst_cnt};
   wire [31:0] src_word  = {20'h00000, src2_cfg, 4'h0, src1_cfg};
   wire [CNT_W-1:0] samp_cnt = pre_cnt + post_cnt;

   assign rd_data = r_stat ? stat_word :
                    r_prog ? prog_word :
                    r_samp ? 32'(samp_cnt) :
                    r_pre  ? 32'(pre_cfg) :
                    r_trig ? 32'(trig_cfg) :
                    r_arm  ? 32'(arm_cfg) :
                    r_src  ? src_word : 32'h0000_0000;

   // ----------------------------------------------------------------------------
   // request_a checks
   // ----------------------------------------------------------------------------
   wire pre_path   = (pre_cfg != '0);                           // see RL19
   wire arm_bad    = pre_path && ((arm_cfg == '0) ||
                     (32'(arm_cfg) > 32'(`ATS_PRE_ARM_MAX)));   // see RL18
   wire init_bad   = arm_bad || (trig_cfg == '0) || (pre_cfg >= trig_cfg);
   wire init_ok    = init_req && is_idle && !init_bad && !abort_req;
   wire init_fail  = init_req && is_idle && init_bad;

   // ----------------------------------------------------------------------------
   // arm and sample events
   // ----------------------------------------------------------------------------
   wire in_warm    = (state == ats_pkg::ATS_WARM);
   wire in_wtrig   = (state == ats_pkg::ATS_WTRIG);
   wire arm_any    = sel_arm || force_req;                      // see RL16, RL17
   wire arm_open   = in_warm || (in_wtrig && !armed);
   wire pre_done   = (pre_cnt == pre_cfg);
   wire arm_go_pre = in_wtrig && !armed && pre_done && (arm_seen || arm_any); // see RL7
   wire arm_go_post = in_warm && arm_any;                       // see RL11
   wire arm_go     = arm_go_pre || arm_go_post;
   wire trig_take  = in_wtrig && trigger_in;                    // see RL14
   wire [CNT_W:0] total_next = {1'b0, pre_cfg} + {1'b0, post_cnt} + {{CNT_W{1'b0}}, 1'b1};
   wire burst_end  = trig_take && armed && (total_next == {1'b0, trig_cfg}); // see RL9, RL12
   wire [ARM_W-1:0] burst_next = burst_cnt + {{(ARM_W-1){1'b0}}, 1'b1};
   wire last_burst = (arm_cfg != '0) && (burst_next == arm_cfg);           // see RL15

   // ----------------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------------
   always_comb begin // see RL1
      next_state = state;
      case (state)
         ats_pkg::ATS_IDLE: begin
            if (init_ok) next_state = ats_pkg::ATS_INIT;
         end
         ats_pkg::ATS_INIT: begin
            next_state = pre_path ? ats_pkg::ATS_WTRIG : ats_pkg::ATS_WARM; // see RL6, RL10
         end
         ats_pkg::ATS_WARM: begin
            if (arm_go_post) next_state = ats_pkg::ATS_WTRIG;   // see RL11
         end
         ats_pkg::ATS_WTRIG: begin
            if (burst_end) next_state = last_burst ? ats_pkg::ATS_IDLE
                                                   : ats_pkg::ATS_INIT; // see RL13
         end
         default: begin
            next_state = ats_pkg::ATS_IDLE;
         end
      endcase
      if (abort_req) next_state = ats_pkg::ATS_IDLE;            // see RL2
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) state <= ats_pkg::ATS_IDLE;                 // see RL2
      else state <= next_state;
   end

   // ----------------------------------------------------------------------------
   // configuration, shared by both channels
   // ----------------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pre_cfg  <= `ATS_RST_PRE;
         trig_cfg <= `ATS_RST_TRIG;
         arm_cfg  <= `ATS_RST_ARMCNT;
         src1_cfg <= `ATS_RST_SRC1;
         src2_cfg <= `ATS_RST_SRC2;
      end else if (cfg_ok) begin
         if (a_pre) pre_cfg <= merged[CNT_W-1:0];               // see RL5
         if (a_trig) trig_cfg <= merged[CNT_W-1:0];
         if (a_armcnt) arm_cfg <= merged[ARM_W-1:0];
         if (a_src && wr_strb[0]) src1_cfg <= wr_data[`ATS_SRC1_LSB +: `ATS_SRC_W];
         if (a_src && wr_strb[1]) src2_cfg <= wr_data[`ATS_SRC2_LSB +: `ATS_SRC_W];
      end
   end

   // ----------------------------------------------------------------------------
   // sequencing counters and flags
   // ----------------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn || state == ats_pkg::ATS_INIT || is_idle) begin
         pre_cnt  <= '0;
         post_cnt <= '0;
      end else if (trig_take && armed) begin
         post_cnt <= post_cnt + {{(CNT_W-1){1'b0}}, 1'b1};      // see RL8
      end else if (trig_take && !pre_done) begin
         pre_cnt <= pre_cnt + {{(CNT_W-1){1'b0}}, 1'b1};        // see RL6
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         burst_cnt <= '0;
         arm_left  <= '0;
      end else if (init_ok) begin
         burst_cnt <= '0;
         arm_left  <= arm_cfg;
      end else begin
         if (burst_end) burst_cnt <= burst_next;                // see RL13
         if (arm_go && arm_left != '0)
            arm_left <= arm_left - {{(ARM_W-1){1'b0}}, 1'b1};   // see RL17
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         armed    <= 1'b0;
         arm_seen <= 1'b0;
         cfg_err  <= 1'b0;
      end else begin
         armed    <= (next_state == ats_pkg::ATS_WTRIG) && (armed || arm_go);
         arm_seen <= (next_state == ats_pkg::ATS_WTRIG) && !armed && !arm_go &&
                     (arm_seen || (arm_open && arm_any));       // see RL7
         if (init_fail || cfg_refuse) cfg_err <= 1'b1;          // see RL3, RL18
         else if (init_ok || cfg_ok) cfg_err <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sample_take <= 2'h0;
         burst_done  <= 1'b0;
      end else begin
         sample_take <= {2{trig_take}};                         // see RL4, RL14
         burst_done  <= burst_end;
      end
   end

   assign seq_state = 2'(state);                                // see RL4
   assign seq_armed = armed;

endmodule : ats_top
`default_nettype wire

//--- ats_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ats_top_chk (
   // clock and reset
   input wire logic       aclk,
   input wire logic       aresetn,
   // watched ports
   input wire logic       trigger_in,
   input wire logic [1:0] sample_take,
   input wire logic       seq_armed,
   input wire logic [1:0] seq_state,
   input wire logic       burst_done
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_SAMPLE: assert property (sample_take != 2'h0 |-> $past(trigger_in) && $past(seq_state) == 2'h2)
      else $error("sample without trigger in wait-trigger");
   AST_PAIR: assert property (sample_take inside {2'h0, 2'h3})
      else $error("channels differ");
   AST_ARMED: assert property (seq_armed |-> seq_state == 2'h2)
      else $error("armed outside wait-trigger");
   AST_IDLE_EXIT: assert property (seq_state == 2'h0 |=> seq_state inside {2'h0, 2'h1})
      else $error("idle left to wrong state");
   AST_INIT_ONE: assert property (seq_state == 2'h1 |=> seq_state != 2'h1)
      else $error("initiated held");
   AST_WARM_EXIT: assert property (seq_state == 2'h3 |=> seq_state != 2'h1)
      else $error("wait-arm left to initiated");
   AST_DONE_SAMPLE: assert property (burst_done |-> sample_take == 2'h3 && $past(seq_armed))
      else $error("burst end without last sample");
   AST_DONE_STATE: assert property (burst_done |-> !seq_armed && seq_state inside {2'h0, 2'h1})
      else $error("burst end state wrong");
   C_DONE: cover property (burst_done);
   C_ARM: cover property ($rose(seq_armed));
   C_WARM: cover property (seq_state == 2'h3 ##1 seq_state == 2'h2);
endmodule : ats_top_chk
bind ats_top ats_top_chk chk_u (.aclk, .aresetn, .trigger_in, .sample_take, .seq_armed,
   .seq_state, .burst_done);
`default_nettype wire

//--- ats_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module ats_src_model (
   // control from bench
   input wire logic       aclk,
   input wire logic [2:0] arm_sel,
   input wire logic       arm_go,
   input wire logic       trig_go,
   // event lines
   output logic [7:0]     arm_in,
   output logic           trigger_in
);
   // one-cycle pulse on any one selected arm line
   always_ff @(posedge aclk) begin
      arm_in     <= arm_go ? (8'h01 << arm_sel) : 8'h00;
      trigger_in <= trig_go;
   end
endmodule : ats_src_model
`default_nettype wire

//--- tb_arm_trigger_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_arm_trigger_sequencer;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, trigger_in, seq_armed, burst_done, arm_go = 0, trig_go = 0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, arm_in;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [2:0] arm_sel = 3'h0;
   logic [1:0] s_axi_bresp, s_axi_rresp, sample_take, seq_state;
   int errors = 0, checks_done = 0, nsamp = 0, nburst = 0;
   ats_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .arm_in, .trigger_in, .sample_take, .seq_armed, .seq_state, .burst_done);
   ats_src_model src_u (.aclk, .arm_sel, .arm_go, .trig_go, .arm_in, .trigger_in);
   initial forever #12.5 aclk = ~aclk;
   always @(negedge aclk) begin
      if (sample_take === 2'h3) nsamp++;
      if (burst_done === 1'b1) nburst++;
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
      logic [4:0] h;
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
      forever begin
         @(negedge aclk) h = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
         @(posedge aclk);
         if (h[4]) s_axi_awvalid <= 0;
         if (h[3]) s_axi_wvalid <= 0;
         if (h[2]) break;
      end
      chk("bresp", r, h[1:0]);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
      logic [35:0] h;
      s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
      forever begin
         @(negedge aclk) h = {s_axi_arready, s_axi_rvalid, s_axi_rresp, s_axi_rdata};
         @(posedge aclk);
         if (h[35]) s_axi_arvalid <= 0;
         if (h[34]) break;
      end
      chk("rresp", r, h[33:32]);
      chk("rdata", e, h[31:0]);
   endtask : rd
   task automatic st(input logic [1:0] e);
      repeat (40) @(negedge aclk) if (seq_state === e) break;
      chk("state", e, seq_state);
      @(posedge aclk);
   endtask : st
   task automatic am(input logic e);
      @(negedge aclk);
      chk("armed", e, seq_armed);
      @(posedge aclk);
   endtask : am
   task automatic trig(input int n);
      repeat (n) begin
         @(posedge aclk) trig_go <= 1;
         @(posedge aclk) trig_go <= 0;
      end
      repeat (3) @(posedge aclk);
   endtask : trig
   task automatic arm(input logic [2:0] s);
      @(posedge aclk) begin arm_sel <= s; arm_go <= 1; end
      @(posedge aclk) arm_go <= 0;
   endtask : arm
   task automatic test_post;
      wr(8'h0C, 2); wr(8'h10, 2); wr(8'h14, 32'h201); nsamp = 0; nburst = 0;
      rd(8'h14, 32'h201);
      wr(8'h00, 1); st(2'h3);
      trig(1); chk("samples", 0, nsamp);
      arm(3'h0); st(2'h2); trig(2); st(2'h3);
      arm(3'h1); st(2'h2); trig(2); st(2'h0);
      chk("samples", 4, nsamp);
      chk("bursts", 2, nburst);
      rd(8'h1C, 32'h2);
      $display("test_post done");
   endtask : test_post
   task automatic test_pre;
      wr(8'h08, 1); rd(8'h04, 1);
      wr(8'h0C, 3); wr(8'h10, 1); wr(8'h14, 0); nsamp = 0; nburst = 0;
      wr(8'h00, 1); st(2'h2);
      trig(1); am(0);
      wr(8'h00, 4); am(1);
      trig(2); st(2'h0); chk("samples", 3, nsamp);
      chk("bursts", 1, nburst);
      $display("test_pre done");
   endtask : test_pre
   task automatic test_abort;
      wr(8'h04, 0); wr(8'h00, 1); st(2'h3);
      wr(8'h0C, 5); rd(8'h0C, 3);
      rd(8'h18, 32'h13);
      wr(8'h00, 2); st(2'h0);
      wr(8'h04, 1); wr(8'h10, 200); wr(8'h00, 1); st(2'h0); rd(8'h18, 32'h10);
      wr(8'h24, 0, 2'h2); rd(8'h24, 0, 2'h2);
      $display("test_abort done");
   endtask : test_abort
   task automatic final_report;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : final_report
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1;
      test_post;
      test_pre;
      test_abort;
      final_report;
   end
   initial begin
      #100000;
      errors++;
      final_report;
   end
endmodule : tb_arm_trigger_sequencer
`default_nettype wire
